//--- hw/phyirq_regs.sv
// Operation
// - Flag bit 7 latches when energy presence is newly generated.
// - Flag bit 6 latches when auto-negotiation completes.
// - Flag bit 5 latches when a remote fault is seen from the partner.
// - Flag bit 4 latches when link status falls.
// - Flag bit 3 latches on the partner acknowledge event.
// - Flag bit 2 latches on a parallel detection fault.
// - Flag bit 1 latches when a negotiation page is received.
// - Flag bits 15 to 8 and bit 0 read as zero.
// - After reset the link-loss flag is set if the link is down.
// - Enable low byte is writable, one enables a source, resets to zero.
// - Enable upper byte reads zero and ignores writes.
// - Status bit 12 reads one only when negotiation is done.
// - Status bits 11 to 5 are writable and reset to 0000010b.
// - Status bits 4 to 2 report the resolved speed and duplex code.
// - Energy presence drops after 256 ms without line energy.
module phyirq_regs #(
   parameter int TICK_CYC = 40000,
   parameter int HOLD_MS  = 256
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Management register port
   input  wire logic [4:0]  reg_idx,
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   // Line and negotiation events
   input  wire logic        line_energy,
   input  wire logic        link_up,
   input  wire logic        neg_done,
   input  wire logic        remote_fault,
   input  wire logic        partner_ack,
   input  wire logic        parallel_fault,
   input  wire logic        page_rcvd,
   input  wire logic [2:0]  resolved_speed_code,
   // Request and energy view
   output logic             irq_req,
   output logic             energy_present_o
);
   import phyirq_pkg::*;

   logic [7:0]  flags_r;
   logic [7:0]  enables_r;
   logic [6:0]  pattern_r;
   logic [7:0]  ev;
   logic        neg_prev_r;
   logic        link_prev_r;
   logic        energy_prev_r;
   logic        init_r;
   logic        energy_present;
   logic        flags_rd;

   phyirq_energy #(
      .TICK_CYC(TICK_CYC),
      .HOLD_MS (HOLD_MS)
   ) u_energy (
      .mclk          (mclk),
      .rst_b         (rst_b),
      .line_energy   (line_energy),
      .energy_present(energy_present)
   );

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         link_prev_r   <= 1'b0;
         energy_prev_r <= 1'b1;
      end else begin
         link_prev_r   <= link_up;
         energy_prev_r <= energy_present;
      end
   end

   always_comb begin
      ev    = 8'h00;
      ev[7] = energy_present && !energy_prev_r;
      ev[6] = neg_done && !neg_prev_r;
      ev[5] = remote_fault;
      ev[4] = link_prev_r && !link_up;
      ev[3] = partner_ack;
      ev[2] = parallel_fault;
      ev[1] = page_rcvd;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         neg_prev_r <= 1'b0;
      end else begin
         neg_prev_r <= neg_done;
      end
   end

   // ------------------------------------------------------------
   // Latching flags, set wins over read clear
   // ------------------------------------------------------------
   assign flags_rd = reg_rd && (reg_idx == PHYIRQ_FLAGS_IDX);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         init_r <= 1'b1;
      end else begin
         init_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flags_r <= 8'h00;
      end else if (init_r) begin
         flags_r <= {3'h0, !link_up, 4'h0} | (ev & PHYIRQ_SRC_MASK);
      end else if (flags_rd) begin
         flags_r <= ev & PHYIRQ_SRC_MASK;
      end else begin
         flags_r <= (flags_r | ev) & PHYIRQ_SRC_MASK;
      end
   end

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         enables_r <= PHYIRQ_EN_RST;
      end else if (reg_wr && reg_idx == PHYIRQ_ENABLES_IDX) begin
         enables_r <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pattern_r <= PHYIRQ_PAT_RST;
      end else if (reg_wr && reg_idx == PHYIRQ_STATUS_IDX) begin
         pattern_r <= reg_wdata[PHYIRQ_PAT_HI:PHYIRQ_PAT_LO];
      end
   end

   // ------------------------------------------------------------
   // Read data and request
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         if (reg_idx == PHYIRQ_FLAGS_IDX) begin
            reg_rdata <= {8'h00, flags_r};
         end else if (reg_idx == PHYIRQ_ENABLES_IDX) begin
            reg_rdata <= {8'h00, enables_r};
         end else if (reg_idx == PHYIRQ_STATUS_IDX) begin
            reg_rdata <= {3'h0, neg_done, pattern_r,
                          resolved_speed_code, 2'h0};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req          <= 1'b0;
         energy_present_o <= 1'b1;
      end else begin
         irq_req          <= |(flags_r & enables_r);
         energy_present_o <= energy_present;
      end
   end

   chk_irq_follows: assert property (@(posedge mclk) disable iff (!rst_b)
      irq_req == $past(|(flags_r & enables_r))) else $error("irq mismatch");
   chk_flag_rsvd: assert property (@(posedge mclk) disable iff (!rst_b)
      flags_r[0] == 1'b0) else $error("reserved flag set");
   chk_link_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      (link_prev_r && !link_up && !init_r) |=> flags_r[4]) else $error("link loss lost");
   chk_page_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      page_rcvd |=> flags_r[1]) else $error("page flag lost");
   chk_ack_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      partner_ack |=> flags_r[3]) else $error("ack flag lost");
   chk_fault_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      remote_fault |=> flags_r[5]) else $error("remote fault flag lost");
   chk_parallel_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      parallel_fault |=> flags_r[2]) else $error("parallel fault flag lost");
   chk_energy_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(energy_present) |=> flags_r[7]) else $error("energy flag lost");
   chk_done_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(neg_done) |=> flags_r[6]) else $error("done flag lost");
   chk_flag_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      (flags_r[6] && !flags_rd && !init_r) |=> flags_r[6]) else $error("flag dropped");
   chk_flags_rd: assert property (@(posedge mclk) disable iff (!rst_b)
      flags_rd |=> (reg_rdata[15:8] == 8'h00 && reg_rdata[0] == 1'b0))
      else $error("reserved flag bits read");
   chk_status_rd: assert property (@(posedge mclk) disable iff (!rst_b)
      (reg_rd && reg_idx == PHYIRQ_STATUS_IDX) |=>
      reg_rdata[4:2] == $past(resolved_speed_code) && reg_rdata[12] == $past(neg_done))
      else $error("status read wrong");
   chk_enable_rd: assert property (@(posedge mclk) disable iff (!rst_b)
      (reg_rd && reg_idx == PHYIRQ_ENABLES_IDX) |=> reg_rdata[15:8] == 8'h00)
      else $error("enable upper byte");
endmodule // phyirq_regs

//--- hw/phyirq_pkg.sv
package phyirq_pkg;
   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [4:0]  PHYIRQ_FLAGS_IDX   = 5'h1D;
   localparam logic [4:0]  PHYIRQ_ENABLES_IDX = 5'h1E;
   localparam logic [4:0]  PHYIRQ_STATUS_IDX  = 5'h1F;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          PHYIRQ_SRC_LO      = 1;
   localparam int          PHYIRQ_SRC_HI      = 7;
   localparam int          PHYIRQ_LINK_BIT    = 4;
   localparam int          PHYIRQ_DONE_BIT    = 12;
   localparam int          PHYIRQ_PAT_LO      = 5;
   localparam int          PHYIRQ_PAT_HI      = 11;
   localparam int          PHYIRQ_SPD_LO      = 2;
   localparam logic [6:0]  PHYIRQ_PAT_RST     = 7'h02;
   localparam logic [7:0]  PHYIRQ_EN_RST      = 8'h00;
   localparam logic [7:0]  PHYIRQ_SRC_MASK    = 8'hFE;
   // ------------------------------------------------------------
   // Speed codes
   // ------------------------------------------------------------
   localparam logic [2:0]  PHYIRQ_SPD_10H     = 3'h1;
   localparam logic [2:0]  PHYIRQ_SPD_10F     = 3'h5;
   localparam logic [2:0]  PHYIRQ_SPD_100H    = 3'h2;
   localparam logic [2:0]  PHYIRQ_SPD_100F    = 3'h6;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint      PHYIRQ_CLK_HZ      = 40000000;
   localparam longint      PHYIRQ_ENERGY_MS   = 256;
   localparam longint      PHYIRQ_ENERGY_CYC  = PHYIRQ_ENERGY_MS * PHYIRQ_CLK_HZ / 1000;
   localparam longint      PHYIRQ_TICK_CYC    = PHYIRQ_CLK_HZ / 1000;
endpackage

//--- hw/phyirq_energy.sv
module phyirq_energy #(
   parameter int TICK_CYC = 40000,
   parameter int HOLD_MS  = 256
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // Line energy
   input  wire logic line_energy,
   output logic      energy_present
);
   import phyirq_pkg::*;

   logic [31:0] tick_cnt_r;
   logic [31:0] ms_cnt_r;
   logic        tick;

   // ------------------------------------------------------------
   // Millisecond enable, restarted by energy
   // ------------------------------------------------------------
   assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= 32'h0;
      end else if (line_energy || tick) begin
         tick_cnt_r <= 32'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   // Resets to one so a live line is not reported dead at power-up
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ms_cnt_r       <= 32'h0;
         energy_present <= 1'b1;
      end else if (line_energy) begin
         ms_cnt_r       <= 32'h0;
         energy_present <= 1'b1;
      end else if (tick) begin
         if (ms_cnt_r == 32'(HOLD_MS - 1)) begin
            energy_present <= 1'b0;
         end else begin
            ms_cnt_r <= ms_cnt_r + 32'h1;
         end
      end
   end
endmodule // phyirq_energy

//--- verif/phyirq_partner.sv
module phyirq_partner (
   // Clock
   input  wire logic  mclk,
   // Management port
   output logic [4:0]  reg_idx,
   output logic        reg_rd,
   output logic        reg_wr,
   output logic [15:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] expq[$];
   initial begin
      reg_idx = 5'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   // One-cycle strobe; released data inverted so stale values never match
   task automatic acc(input logic [4:0] idx, input logic rd, input logic [15:0] d);
      @(negedge mclk);
      reg_idx <= idx;
      reg_rd <= rd;
      reg_wr <= !rd;
      reg_wdata <= d;
      @(negedge mclk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [4:0] idx, input logic [15:0] e);
      expq.push_back(e);
      acc(idx, 1'b1, 16'h0000);
   endtask
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      acc(idx, 1'b0, d);
   endtask
endmodule // phyirq_partner

//--- verif/test_phy_interrupt_status_regs.sv
module test_phy_interrupt_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import phyirq_pkg::*;
   logic        mclk, rst_b, line_energy, link_up, pend;
   logic [7:0]  ev;
   logic [2:0]  spd;
   logic [4:0]  reg_idx;
   logic        reg_rd, reg_wr, irq_req, energy_present_o;
   logic [15:0] reg_wdata, reg_rdata, w;
   logic [2:0]  codes [4] = '{PHYIRQ_SPD_10H, PHYIRQ_SPD_10F, PHYIRQ_SPD_100H, PHYIRQ_SPD_100F};
   int          miscompares, n_compared;
   // ------------------------------------------------------------
   // Design and management master
   // ------------------------------------------------------------
   // Short energy timeout: 3 ticks of 4 cycles
   phyirq_regs #(.TICK_CYC(4), .HOLD_MS(3)) dut (
      .mclk, .rst_b, .reg_idx, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
      .line_energy, .link_up, .neg_done(ev[6]), .remote_fault(ev[5]),
      .partner_ack(ev[3]), .parallel_fault(ev[2]), .page_rcvd(ev[1]),
      .resolved_speed_code(spd), .irq_req, .energy_present_o);
   phyirq_partner p (.mclk, .reg_idx, .reg_rd, .reg_wr, .reg_wdata);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk) pend <= reg_rd;
   always @(negedge mclk) if (pend) chk("rdata", p.expq.pop_front(), reg_rdata);
   initial begin
      repeat (4000) @(posedge mclk);
      miscompares++;
      give_verdict;
   end
   // One-cycle event; bit 4 means a link drop
   task automatic pulse(input int b);
      @(negedge mclk);
      ev[b] <= 1'b1;
      link_up <= (b != 4);
      @(negedge mclk);
      ev[b] <= 1'b0;
      link_up <= 1'b1;
      repeat (2) @(negedge mclk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      line_energy = 1'b1;
      link_up = 1'b0;
      ev = 8'h00;
      spd = PHYIRQ_SPD_100F;
      pend = 1'b0;
      miscompares = 0;
      n_compared = 0;
      void'($urandom(32'h9aa38078));
      repeat (5) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      link_up = 1'b1;
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0010);
      p.wr(PHYIRQ_FLAGS_IDX, 16'hFFFF);
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0000);
      p.rd(5'h00, 16'h0000);
      p.rd(PHYIRQ_ENABLES_IDX, 16'h0000);
      p.rd(PHYIRQ_STATUS_IDX, {4'h0, PHYIRQ_PAT_RST, spd, 2'h0});
      for (int b = 1; b <= 6; b++) begin
         pulse(b);
         p.rd(PHYIRQ_FLAGS_IDX, 16'h0001 << b);
      end
      ev[6] = 1'b1;
      p.wr(PHYIRQ_STATUS_IDX, {4'hF, PHYIRQ_PAT_RST, 5'h1C});
      foreach (codes[i]) begin
         spd = codes[i];
         p.rd(PHYIRQ_STATUS_IDX, {4'h1, PHYIRQ_PAT_RST, spd, 2'h0});
      end
      ev[6] = 1'b0;
      p.wr(PHYIRQ_STATUS_IDX, {4'h0, PHYIRQ_PAT_RST, 5'h00});
      p.rd(PHYIRQ_STATUS_IDX, {4'h0, PHYIRQ_PAT_RST, spd, 2'h0});
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0040);
      w = 16'($urandom);
      p.wr(PHYIRQ_ENABLES_IDX, {8'h00, w[7:0]});
      p.rd(PHYIRQ_ENABLES_IDX, {8'h00, w[7:0]});
      p.wr(PHYIRQ_ENABLES_IDX, 16'h0002);
      pulse(1);
      chk("irq_req", 16'h0001, {15'h0, irq_req});
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0002);
      repeat (2) @(negedge mclk);
      chk("irq_req", 16'h0000, {15'h0, irq_req});
      p.wr(PHYIRQ_ENABLES_IDX, 16'h00FD);
      pulse(1);
      chk("irq_req", 16'h0000, {15'h0, irq_req});
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0002);
      line_energy = 1'b0;
      repeat (10) @(negedge mclk);
      chk("energy", 16'h0001, {15'h0, energy_present_o});
      repeat (20) @(negedge mclk);
      chk("energy", 16'h0000, {15'h0, energy_present_o});
      line_energy = 1'b1;
      repeat (3) @(negedge mclk);
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0080);
      // ------------------------------------------------------------
      // Reset in mid-run with a request pending
      // ------------------------------------------------------------
      p.wr(PHYIRQ_ENABLES_IDX, 16'h0002);
      pulse(1);
      chk("irq_req", 16'h0001, {15'h0, irq_req});
      rst_b = 1'b0;
      @(negedge mclk);
      chk("irq_rst", 16'h0000, {15'h0, irq_req});
      chk("rdata_rst", 16'h0000, reg_rdata);
      chk("energy_rst", 16'h0001, {15'h0, energy_present_o});
      repeat (4) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      p.rd(PHYIRQ_FLAGS_IDX, 16'h0000);
      p.rd(PHYIRQ_ENABLES_IDX, 16'h0000);
      repeat (3) @(negedge mclk);
      give_verdict;
   end
endmodule // test_phy_interrupt_status_regs
